// File: design/ucg_params.svh
// Constants of the USB clock generator control block
//
// Contract
// RULE_01: Produce a 48 MHz USB clock from an 8, 12, 16 or 20 MHz input.
// RULE_02: Input is the 12 MHz oscillator or system clock at an allowed rate.
// RULE_03: Gate/status register resets to 00; low four bits clear on soft reset.
// RULE_04: Gate bit 1 withholds function clock; 0 supplies it.
// RULE_05: While gated, USB register writes and read side effects are blocked.
// RULE_06: Long bus idle sets suspend-in flag; next bus change sets suspend-out.
// RULE_07: Suspend-out flag setting clears the gate bit in the same cycle.
// RULE_08: Gate bit sets only on writing 1 after reading 0 while suspended.
// RULE_09: Software sets the gate bit only after its suspend handling.
// RULE_10: Reset-control register goes to 7F on reset or hardware standby.
// RULE_11: Hub DPLL reset bit 1 holds hub DPLL in reset; 0 releases it.
// RULE_12: Function DPLL reset bit 1 holds it in reset; 0 releases it.
// RULE_13: Software clears DPLL reset bits only after the PLL has settled.
// RULE_14: PLL control register goes to 01 on reset or hardware standby.
// RULE_15: Source select decodes halted, prohibited, bypass, system or oscillator.
// RULE_16: Oscillator runs only while select top and bottom bits are both 1.
// RULE_17: Frequency field gives PLL input rate 8, 12, 16 or 20 MHz.
// RULE_18: Gate/status upper four bits are read-only port connection flags.
// RULE_19: PLL control upper three bits read zero and ignore writes.
`ifndef UCG_PARAMS_SVH
`define UCG_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define UCG_ADDR_GATE 16'hFDF5
`define UCG_ADDR_RSTC 16'hFDFD
`define UCG_ADDR_PLL 16'hFDFE
`define UCG_ADDR_IRQ_STAT 16'hFDF0
`define UCG_ADDR_IRQ_MASK 16'hFDF1

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define UCG_GATE_RST 8'h00
`define UCG_RSTC_RST 8'h7F
`define UCG_PLL_RST 8'h01
`define UCG_PLL_WMASK 8'h1F
`define UCG_BIT_GATE 0
`define UCG_BIT_HUB_DPLL 3
`define UCG_BIT_FN_DPLL 1
`define UCG_BIT_SUSP_IN 0
`define UCG_BIT_SUSP_OUT 1

// ----------------------------------------
// Timing
// ----------------------------------------
`define UCG_CLK_MHZ 200
`define UCG_IDLE_US 3000
`define UCG_IDLE_CYC (`UCG_IDLE_US * `UCG_CLK_MHZ)

// ----------------------------------------
// PLL ratios to reach 48 MHz
// ----------------------------------------
`define UCG_MUL_8M 4'h6
`define UCG_MUL_12M 4'h4
`define UCG_MUL_16M 4'h3
`define UCG_MUL_20M 4'hC
`define UCG_DIV_20M 3'h5
`define UCG_DIV_ONE 3'h1

`endif

// File: design/ucg_pkg.sv
// Types of the USB clock generator control block
package ucg_pkg;

    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_BYPASS,
        SRC_SYS,
        SRC_OSC
    } ucg_src_e;

    typedef enum logic {
        ST_ACTIVE,
        ST_SUSPEND
    } ucg_susp_e;

    typedef struct packed {
        ucg_src_e src;
        logic pll_en;
        logic osc_en;
        logic [3:0] mul;
        logic [2:0] div;
    } ucg_pll_s;

endpackage : ucg_pkg

// File: design/ucg_top.sv
// USB clock generator control: registers, clock gate, suspend, PLL steering
`timescale 1ns/1ps
`include "ucg_params.svh"

module ucg_top #(
    parameter int IDLE_CYCLES = `UCG_IDLE_CYC
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Partner USB logic
    input wire logic bus_idle_i,
    input wire logic func_soft_reset_i,
    input wire logic [3:0] downstream_port_connected_i,
    // Hardware standby pin
    input wire logic hw_standby_i,
    // Clock and reset controls
    output ucg_pkg::ucg_pll_s pll_o,
    output logic func_clock_en_o,
    output logic usb_access_block_o,
    output logic hub_dpll_soft_reset_o,
    output logic function_dpll_soft_reset_o,
    // Interrupt
    output logic irq_o
);

    // ----------------------------------------
    // Hardware standby synchroniser
    // ----------------------------------------
    logic [2:0] stby_sync_q;
    logic stby_q;

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            stby_sync_q <= 3'h0;
        end else begin
            stby_sync_q <= {stby_sync_q[1:0], hw_standby_i};
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            stby_q <= 1'b0;
        end else if (stby_sync_q[1] == stby_sync_q[2]) begin
            stby_q <= stby_sync_q[2];
        end
    end

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    logic wr_gate, wr_rstc, wr_pll, wr_stat, wr_mask, rd_gate;

    assign wr_gate = wr_i && (addr_i == `UCG_ADDR_GATE);
    assign wr_rstc = wr_i && (addr_i == `UCG_ADDR_RSTC);
    assign wr_pll = wr_i && (addr_i == `UCG_ADDR_PLL);
    assign wr_stat = wr_i && (addr_i == `UCG_ADDR_IRQ_STAT);
    assign wr_mask = wr_i && (addr_i == `UCG_ADDR_IRQ_MASK);
    assign rd_gate = rd_i && (addr_i == `UCG_ADDR_GATE);

    // ----------------------------------------
    // Suspend detection
    // ----------------------------------------
    ucg_pkg::ucg_susp_e susp_q;
    logic [31:0] idle_cnt_q;
    logic susp_in_evt, susp_out_evt;

    assign susp_in_evt = (susp_q == ucg_pkg::ST_ACTIVE) && bus_idle_i
        && (idle_cnt_q == 32'(IDLE_CYCLES - 1)); // see RULE_06
    assign susp_out_evt = (susp_q == ucg_pkg::ST_SUSPEND)
        && !bus_idle_i; // see RULE_06

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q || !bus_idle_i) begin
            idle_cnt_q <= 32'h0;
        end else if (idle_cnt_q != 32'(IDLE_CYCLES - 1)) begin
            idle_cnt_q <= idle_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q) begin
            susp_q <= ucg_pkg::ST_ACTIVE;
        end else begin
            case (susp_q)
                ucg_pkg::ST_ACTIVE: begin
                    if (susp_in_evt) begin
                        susp_q <= ucg_pkg::ST_SUSPEND;
                    end
                end
                ucg_pkg::ST_SUSPEND: begin
                    if (susp_out_evt) begin
                        susp_q <= ucg_pkg::ST_ACTIVE;
                    end
                end
                default: susp_q <= ucg_pkg::ST_ACTIVE;
            endcase
        end
    end

    // ----------------------------------------
    // Clock gate and status register
    // ----------------------------------------
    logic [3:0] gate_q;
    logic armed_q;
    logic in_susp;

    assign in_susp = (susp_q == ucg_pkg::ST_SUSPEND);

    // Arming needs a read of 0 during suspend, so a stale write cannot gate
    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q || func_soft_reset_i || !in_susp) begin
            armed_q <= 1'b0;
        end else if (rd_gate && !gate_q[`UCG_BIT_GATE]) begin
            armed_q <= 1'b1; // see RULE_08
        end else if (gate_q[`UCG_BIT_GATE]) begin
            armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q) begin
            gate_q <= 4'(`UCG_GATE_RST); // see RULE_03
        end else if (func_soft_reset_i) begin
            gate_q <= 4'h0; // see RULE_03
        end else begin
            if (wr_gate) begin
                gate_q[3:1] <= wdata_i[3:1];
            end
            if (susp_out_evt) begin
                gate_q[`UCG_BIT_GATE] <= 1'b0; // see RULE_07
            end else if (wr_gate && !wdata_i[`UCG_BIT_GATE]) begin
                gate_q[`UCG_BIT_GATE] <= 1'b0;
            end else if (wr_gate && armed_q && in_susp) begin
                gate_q[`UCG_BIT_GATE] <= 1'b1; // see RULE_08
            end
        end
    end

    // ----------------------------------------
    // Reset control and PLL control registers
    // ----------------------------------------
    logic [7:0] rstc_q;
    logic [4:0] pll_q;

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q) begin
            rstc_q <= `UCG_RSTC_RST; // see RULE_10
        end else if (wr_rstc) begin
            rstc_q <= wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q) begin
            pll_q <= 5'(`UCG_PLL_RST); // see RULE_14
        end else if (wr_pll) begin
            pll_q <= wdata_i[4:0]; // see RULE_19
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    logic [1:0] stat_q, mask_q, stat_d;

    // A new event wins over a write-one clear in the same cycle
    always_comb begin
        stat_d = stat_q;
        if (wr_stat) begin
            stat_d = stat_q & ~wdata_i[1:0];
        end
        stat_d[`UCG_BIT_SUSP_IN] = stat_d[`UCG_BIT_SUSP_IN] | susp_in_evt;
        stat_d[`UCG_BIT_SUSP_OUT] = stat_d[`UCG_BIT_SUSP_OUT] | susp_out_evt;
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= stat_d; // see RULE_06
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i || stby_q) begin
            mask_q <= 2'h0;
        end else if (wr_mask) begin
            mask_q <= wdata_i[1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_q & mask_q);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (!rd_i) begin
            rdata_o <= 8'h00;
        end else if (addr_i == `UCG_ADDR_GATE) begin
            rdata_o <= {downstream_port_connected_i, gate_q}; // see RULE_18
        end else if (addr_i == `UCG_ADDR_RSTC) begin
            rdata_o <= rstc_q;
        end else if (addr_i == `UCG_ADDR_PLL) begin
            rdata_o <= {3'h0, pll_q}; // see RULE_19
        end else if (addr_i == `UCG_ADDR_IRQ_STAT) begin
            rdata_o <= {6'h00, stat_q};
        end else if (addr_i == `UCG_ADDR_IRQ_MASK) begin
            rdata_o <= {6'h00, mask_q};
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------
    // PLL steering
    // ----------------------------------------
    ucg_pkg::ucg_pll_s pll_d;

    // Select 100 is prohibited; it is treated as halted to stay safe
    always_comb begin
        pll_d = '0;
        pll_d.src = ucg_pkg::SRC_OFF;
        case (pll_q[4:2])
            3'h5: pll_d.src = ucg_pkg::SRC_BYPASS; // see RULE_15
            3'h6: pll_d.src = ucg_pkg::SRC_SYS; // see RULE_02
            3'h7: pll_d.src = ucg_pkg::SRC_OSC; // see RULE_02
            default: pll_d.src = ucg_pkg::SRC_OFF; // see RULE_15
        endcase
        pll_d.pll_en = pll_q[4] && pll_q[3]; // see RULE_15
        pll_d.osc_en = pll_q[4] && pll_q[2]; // see RULE_16
        pll_d.div = `UCG_DIV_ONE;
        case (pll_q[1:0])
            2'h0: pll_d.mul = `UCG_MUL_8M; // see RULE_17
            2'h1: pll_d.mul = `UCG_MUL_12M; // see RULE_17
            2'h2: pll_d.mul = `UCG_MUL_16M; // see RULE_17
            default: begin
                pll_d.mul = `UCG_MUL_20M; // see RULE_01
                pll_d.div = `UCG_DIV_20M;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            pll_o <= '0;
        end else begin
            pll_o <= pll_d;
        end
    end

    // ----------------------------------------
    // Clock gate and DPLL reset outputs
    // ----------------------------------------
    // DPLL release timing is left to software after the PLL settles
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            func_clock_en_o <= 1'b1;
            usb_access_block_o <= 1'b0;
            hub_dpll_soft_reset_o <= 1'b1;
            function_dpll_soft_reset_o <= 1'b1;
        end else begin
            func_clock_en_o <= !gate_q[`UCG_BIT_GATE]; // see RULE_04
            usb_access_block_o <= gate_q[`UCG_BIT_GATE]; // see RULE_05
            hub_dpll_soft_reset_o <= rstc_q[`UCG_BIT_HUB_DPLL]; // see RULE_11
            function_dpll_soft_reset_o <=
                rstc_q[`UCG_BIT_FN_DPLL]; // see RULE_12
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    chk_osc_enable: assert property ( // see RULE_16
        ##1 pll_o.osc_en == ($past(pll_q[4]) && $past(pll_q[2])))
        else $error("oscillator enable does not follow select");
    chk_gate_clear: assert property ( // see RULE_07
        susp_out_evt && !stby_q |=> !gate_q[0] ##1 func_clock_en_o)
        else $error("suspend-out did not restore clock");
    chk_gate_set_cause: assert property ( // see RULE_08
        $rose(gate_q[0]) |-> $past(armed_q) && $past(wr_gate)
        && $past(in_susp))
        else $error("gate bit set without read-then-write");
    chk_pll_upper_zero: assert property ( // see RULE_19
        rd_i && addr_i == `UCG_ADDR_PLL |=> rdata_o[7:5] == 3'h0)
        else $error("PLL control upper bits not zero");
    chk_port_flags: assert property ( // see RULE_18
        rd_gate |=> rdata_o[7:4] == $past(downstream_port_connected_i))
        else $error("port flags not reported");
    chk_hub_dpll: assert property ( // see RULE_11
        wr_rstc && !stby_q |=> ##1
        hub_dpll_soft_reset_o == $past(wdata_i[3], 2))
        else $error("hub DPLL reset not following register");
    chk_fsr_clear: assert property ( // see RULE_03
        func_soft_reset_i |=> gate_q == 4'h0 ##1 func_clock_en_o)
        else $error("function soft reset left gate bits set");
    chk_prohibited_sel: assert property ( // see RULE_15
        pll_q[4:2] == 3'h4 |=> !pll_o.pll_en
        && pll_o.src == ucg_pkg::SRC_OFF)
        else $error("prohibited select not halted");
    chk_reset_values: assert property ( // see RULE_14
        $rose(nrst_i) |-> rstc_q == `UCG_RSTC_RST
        && pll_q == 5'(`UCG_PLL_RST) && gate_q == 4'h0)
        else $error("reset values wrong");
    chk_susp_in_flag: assert property ( // see RULE_06
        susp_in_evt && !stby_q |=> stat_q[0] && in_susp)
        else $error("suspend-in flag not set");
    chk_fn_dpll: assert property ( // see RULE_12
        wr_rstc && !stby_q |=> ##1
        function_dpll_soft_reset_o == $past(wdata_i[1], 2))
        else $error("function DPLL reset not following register");
    chk_clock_withheld: assert property ( // see RULE_04
        $rose(gate_q[0]) |=> !func_clock_en_o && usb_access_block_o)
        else $error("function clock not withheld while gated");
    chk_pll_ratio_12m: assert property ( // see RULE_17
        nrst_i && pll_q[1:0] == 2'h1 |=> pll_o.mul == `UCG_MUL_12M
        && pll_o.div == `UCG_DIV_ONE)
        else $error("12 MHz input ratio wrong");
    chk_write_blocked: assert property ( // see RULE_05
        gate_q[0] |=> usb_access_block_o)
        else $error("USB access not blocked while gated");

    cov_gate_set: cover property ($rose(gate_q[0]));
    cov_susp_out: cover property (susp_out_evt && gate_q[0]);
    cov_bypass: cover property (pll_o.src == ucg_pkg::SRC_BYPASS);
    cov_irq: cover property ($rose(irq_o));

endmodule : ucg_top

// File: dv/ucg_usb_partner.sv
// Behavioural model of the USB function and hub logic facing the block
`timescale 1ns/1ps

module ucg_usb_partner (
    // Clock
    input wire logic clock_i,
    // Signals towards the block
    output logic bus_idle_o,
    output logic soft_reset_o,
    output logic [3:0] port_conn_o
);
    // ----------------------------------------
    // Start with an active bus and nothing connected
    // ----------------------------------------
    initial begin
        bus_idle_o = 1'b0;
        soft_reset_o = 1'b0;
        port_conn_o = 4'h0;
    end

    // Bus state changes land just after an edge, held as a level
    task set_idle(input logic v);
        @(posedge clock_i);
        bus_idle_o <= v;
    endtask : set_idle

    // One cycle soft reset of the function
    task pulse_reset();
        @(posedge clock_i);
        soft_reset_o <= 1'b1;
        @(posedge clock_i);
        soft_reset_o <= 1'b0;
    endtask : pulse_reset

    task connect(input logic [3:0] p);
        @(posedge clock_i);
        port_conn_o <= p;
    endtask : connect
endmodule : ucg_usb_partner

// File: dv/test_ucg_top.sv
// Self-checking testbench of the USB clock generator control block
`timescale 1ns/1ps
`include "ucg_params.svh"

module test_ucg_top;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic hw_standby_i = 1'b0;
    logic [7:0] rdata_o;
    logic bus_idle;
    logic soft_rst;
    logic [3:0] ports;
    ucg_pkg::ucg_pll_s pll_o;
    logic func_clock_en_o;
    logic usb_access_block_o;
    logic hub_rst;
    logic fn_rst;
    logic irq_o;
    int error_cnt = 0;
    int n_compared = 0;

    always #2.5 clock_i = ~clock_i;

    // Short idle count keeps the suspend scenario brief
    ucg_top #(.IDLE_CYCLES(20)) dut_u (
        .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .bus_idle_i(bus_idle), .func_soft_reset_i(soft_rst),
        .downstream_port_connected_i(ports), .hw_standby_i(hw_standby_i),
        .pll_o(pll_o), .func_clock_en_o(func_clock_en_o),
        .usb_access_block_o(usb_access_block_o),
        .hub_dpll_soft_reset_o(hub_rst),
        .function_dpll_soft_reset_o(fn_rst), .irq_o(irq_o));

    ucg_usb_partner part_u (
        .clock_i(clock_i), .bus_idle_o(bus_idle),
        .soft_reset_o(soft_rst), .port_conn_o(ports));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata_o});
    endtask : rd

    task wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : wait_cyc

    // Expected PLL steering for a source/frequency setting
    function automatic logic [10:0] pll_exp(input logic [4:0] v);
        logic [1:0] s;
        logic [1:0] en;
        logic [6:0] md;
        case (v[1:0])
            2'h0: md = {4'h6, 3'h1};
            2'h1: md = {4'h4, 3'h1};
            2'h2: md = {4'h3, 3'h1};
            default: md = {4'hC, 3'h5};
        endcase
        case (v[4:2])
            3'h5: {s, en} = {2'h1, 2'h1};
            3'h6: {s, en} = {2'h2, 2'h2};
            3'h7: {s, en} = {2'h3, 2'h3};
            default: {s, en} = 4'h0;
        endcase
        return {s, en, md};
    endfunction : pll_exp

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset_values();
        chk("fclk_en", 16'h1, {15'h0, func_clock_en_o});
        chk("hub_rst", 16'h1, {15'h0, hub_rst});
        chk("fn_rst", 16'h1, {15'h0, fn_rst});
        rd(`UCG_ADDR_GATE, 8'h00);
        rd(`UCG_ADDR_RSTC, 8'h7F);
        rd(`UCG_ADDR_PLL, 8'h01);
        rd(16'hFDF7, 8'h00);
        wr(`UCG_ADDR_RSTC, 8'h00);
        wr(`UCG_ADDR_PLL, 8'h1C);
        hw_standby_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        hw_standby_i <= 1'b0;
        wait_cyc(6);
        chk("hub_rst", 16'h1, {15'h0, hub_rst});
        rd(`UCG_ADDR_RSTC, 8'h7F);
        rd(`UCG_ADDR_PLL, 8'h01);
    endtask : t_reset_values

    // Every source and frequency code, upper bits written as ones
    task t_pll_decode();
        for (int i = 0; i < 32; i++) begin
            wr(`UCG_ADDR_PLL, {3'h7, i[4:0]});
            rd(`UCG_ADDR_PLL, {3'h0, i[4:0]});
            wait_cyc(2);
            chk("pll", {5'h0, pll_exp(i[4:0])}, {5'h0, pll_o});
        end
        chk("osc_en", 16'h1, {15'h0, pll_o.osc_en});
    endtask : t_pll_decode

    // DPLLs released one at a time once the PLL has settled
    task t_dpll_release();
        wait_cyc(50);
        wr(`UCG_ADDR_RSTC, 8'h77);
        wait_cyc(2);
        chk("hub_rst", 16'h0, {15'h0, hub_rst});
        chk("fn_rst", 16'h1, {15'h0, fn_rst});
        wr(`UCG_ADDR_RSTC, 8'h75);
        wait_cyc(2);
        chk("fn_rst", 16'h0, {15'h0, fn_rst});
        rd(`UCG_ADDR_RSTC, 8'h75);
    endtask : t_dpll_release

    task t_suspend();
        wr(`UCG_ADDR_GATE, 8'h01);
        rd(`UCG_ADDR_GATE, 8'h00);
        part_u.set_idle(1'b1);
        wait_cyc(30);
        rd(`UCG_ADDR_IRQ_STAT, 8'h01);
        chk("irq_masked", 16'h0, {15'h0, irq_o});
        wr(`UCG_ADDR_IRQ_MASK, 8'h03);
        wait_cyc(2);
        chk("irq", 16'h1, {15'h0, irq_o});
        wr(`UCG_ADDR_GATE, 8'h01);
        rd(`UCG_ADDR_GATE, 8'h00);
        // Suspend handling done, now stop the function clock
        wr(`UCG_ADDR_GATE, 8'h01);
        wait_cyc(2);
        rd(`UCG_ADDR_GATE, 8'h01);
        chk("fclk_en", 16'h0, {15'h0, func_clock_en_o});
        chk("blk", 16'h1, {15'h0, usb_access_block_o});
        part_u.set_idle(1'b0);
        wait_cyc(3);
        chk("fclk_en", 16'h1, {15'h0, func_clock_en_o});
        chk("blk", 16'h0, {15'h0, usb_access_block_o});
        rd(`UCG_ADDR_GATE, 8'h00);
        rd(`UCG_ADDR_IRQ_STAT, 8'h03);
        wr(`UCG_ADDR_IRQ_STAT, 8'h03);
        rd(`UCG_ADDR_IRQ_STAT, 8'h00);
        wait_cyc(2);
        chk("irq", 16'h0, {15'h0, irq_o});
    endtask : t_suspend

    task t_soft_reset();
        part_u.connect(4'hA);
        wr(`UCG_ADDR_GATE, 8'h5E);
        wait_cyc(2);
        rd(`UCG_ADDR_GATE, 8'hAE);
        part_u.pulse_reset();
        wait_cyc(2);
        rd(`UCG_ADDR_GATE, 8'hA0);
    endtask : t_soft_reset

    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    task results();
        $display("Comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        results();
    end

    initial begin
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        wait_cyc(3);
        t_reset_values();
        t_pll_decode();
        t_dpll_release();
        t_suspend();
        t_soft_reset();
        results();
    end
endmodule : test_ucg_top
